/* ipps_defs.vh */
// constants shared by the interval pulse and pwm sequencer
`ifndef IPPS_DEFS_VH
`define IPPS_DEFS_VH
// -----------------------------------------------------------------
// tick timing
// -----------------------------------------------------------------
`define IPPS_TICK_PS        15000
`define IPPS_CLK_PS         20000
`define IPPS_CYC_PER_TICK   (((`IPPS_TICK_PS) + (`IPPS_CLK_PS) - 1) / (`IPPS_CLK_PS))
// -----------------------------------------------------------------
// register map (word index on the plain port)
// -----------------------------------------------------------------
`define IPPS_A_CTRL         8'h00
`define IPPS_A_STATUS       8'h01
`define IPPS_A_COUNT        8'h02
`define IPPS_A_SWTRIG       8'h03
`define IPPS_A_SAVE         8'h04
`define IPPS_A_RESTORE      8'h05
`define IPPS_A_TBL_BASE     8'h80
// per-interval table field codes: address = base | entry<<3 | field
`define IPPS_F_LEN          3'h0
`define IPPS_F_EXP_ON       3'h1
`define IPPS_F_EXP_OFF      3'h2
`define IPPS_F_STB_ON       3'h3
`define IPPS_F_STB_OFF      3'h4
`define IPPS_F_PWM_PER      3'h5
`define IPPS_F_PWM_DUTY     3'h6
// control bits
`define IPPS_B_RUN          0
`define IPPS_B_PWM          1
`define IPPS_B_HW_TRIG      2
`define IPPS_B_SW_TRIG      3
`define IPPS_B_STB_POL      4
`define IPPS_CTRL_RST       5'h00
`endif

/* ipps_pwm_chan.v */
// one pwm channel: high for the first duty ticks of each period
`timescale 1ns/1ps
module ipps_pwm_chan
#(
  parameter TW = 32
)
(
  input  wire          clk,
  input  wire          rst,
  input  wire          en,
  input  wire          tick,
  input  wire [TW-1:0] pwm_cnt,
  input  wire [TW-1:0] duty,
  output reg           pwm_o
);
  // -----------------------------------------------------------------
  // output register
  // -----------------------------------------------------------------
  // full rail swing only; duty alone sets intensity
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_o <= 1'b0;
    else if (!en)
      pwm_o <= 1'b0;   // idle low
    else if (tick)
      pwm_o <= (pwm_cnt < duty);
  end
endmodule

/* ipps_seq.v */
// interval sequencer with exposure/strobe windows and four pwm channels
`timescale 1ns/1ps
//
// Overview of operation
// - all times counted in 20 ns ticks, 15 ns rounded up to one clock
// - each interval lasts its programmed length
// - exposure window rises at its start tick
// - exposure window falls at stop, interval-relative
// - strobe window rises at its start tick
// - strobe window falls at stop, interval-relative
// - every interval has its own parameter set
// - four pwm channels, duty from on-time
// - pwm swings full rail, duty only
// - trigger starts run from interval zero
// - up to sixteen intervals programmable
// - configuration can be saved and restored
// - trigger from input line or software
// - pulse-length exposure follows window pulses
// - pwm and pulses exported for routing
// - strobe output polarity selectable
`include "ipps_defs.vh"
module ipps_seq
#(
  parameter TW = 32,                 // tick counter width
  parameter NI = 16,                 // interval slots
  parameter NC = 4                   // pwm channels
)
(
  input  wire          clk,
  input  wire          rst,
  input  wire [7:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  input  wire          trig_line,   // hardware input line 1
  output reg           exp_pulse,   // exposure window pulse
  output reg           stb_pulse,   // strobe window, polarity applied
  output reg           sensor_exp,  // sensor integrates while high
  output wire [NC-1:0] pwm_out,     // straight from each channel flop
  output reg           busy
);
  // -----------------------------------------------------------------
  // configuration storage
  // -----------------------------------------------------------------
  reg [TW-1:0] len_m   [0:NI-1];        // interval length
  reg [TW-1:0] eon_m   [0:NI-1];        // exposure start
  reg [TW-1:0] eoff_m  [0:NI-1];        // exposure stop
  reg [TW-1:0] son_m   [0:NI-1];        // strobe start
  reg [TW-1:0] soff_m  [0:NI-1];        // strobe stop
  reg [TW-1:0] per_m   [0:NI-1];        // pwm period
  reg [TW-1:0] duty_m  [0:NI*NC-1];     // pwm on-time per channel
  reg [TW-1:0] shadow_m[0:NI*6-1];      // retained copy of the timing fields
  reg [TW-1:0] shadow_d[0:NI*NC-1];     // retained copy of every on-time
  reg [4:0]    ctrl_r;                  // control bits
  reg [4:0]    cnt_r;                   // programmed interval count
  reg [4:0]    shadow_ctrl_r;
  reg [4:0]    shadow_cnt_r;
  // -----------------------------------------------------------------
  // run state
  // -----------------------------------------------------------------
  localparam S_IDLE = 1'b0;
  localparam S_RUN  = 1'b1;
  reg          state_r;
  reg [3:0]    idx_r;                   // current interval
  reg [TW-1:0] t_r;                     // ticks since interval start
  reg [TW-1:0] pc_r;                    // pwm period counter
  reg [1:0]    pre_r;                   // tick prescaler
  reg          tick;
  reg [2:0]    sync_r;                  // input line synchroniser
  reg          line_q;                  // filtered line level
  reg          swtrig_r;                // software trigger pulse
  reg          restore_r;
  integer      k;
  // -----------------------------------------------------------------
  // tick generator
  // -----------------------------------------------------------------
  // 15 ns cannot be hit at 20 ns; one tick per rounded-up cycle count
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_r <= 2'h0;
      tick  <= 1'b0;
    end
    else if (pre_r >= `IPPS_CYC_PER_TICK - 1)
    begin
      pre_r <= 2'h0;
      tick  <= 1'b1;
    end
    else
    begin
      pre_r <= pre_r + 2'h1;
      tick  <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // trigger input synchroniser
  // -----------------------------------------------------------------
  // stage 0 feeds stage 1 only; level accepted once 1 and 2 agree
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_r <= 3'h0;
      line_q <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], trig_line};
      if (sync_r[1] == sync_r[2])
        line_q <= sync_r[2];
    end
  end
  wire line_rise = sync_r[1] & sync_r[2] & ~line_q;
  wire trig = (ctrl_r[`IPPS_B_HW_TRIG] & line_rise) | swtrig_r;
  // -----------------------------------------------------------------
  // register writes, save and restore
  // -----------------------------------------------------------------
  wire       tbl_sel = reg_addr[7];
  wire [3:0] w_ent   = reg_addr[6:3];
  wire [2:0] w_fld   = reg_addr[2:0];
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r        <= `IPPS_CTRL_RST;
      cnt_r         <= 5'h00;
      swtrig_r      <= 1'b0;
      restore_r     <= 1'b0;
      shadow_ctrl_r <= `IPPS_CTRL_RST;
      shadow_cnt_r  <= 5'h00;
    end
    else
    begin
      swtrig_r  <= reg_wr && reg_addr == `IPPS_A_SWTRIG && ctrl_r[`IPPS_B_SW_TRIG];
      restore_r <= reg_wr && reg_addr == `IPPS_A_RESTORE;
      if (reg_wr && reg_addr == `IPPS_A_CTRL)
        ctrl_r <= reg_wdata[4:0];
      else if (restore_r)
        ctrl_r <= shadow_ctrl_r;
      if (reg_wr && reg_addr == `IPPS_A_COUNT)
        cnt_r <= (reg_wdata[4:0] > NI) ? NI[4:0] : reg_wdata[4:0];
      else if (restore_r)
        cnt_r <= shadow_cnt_r;
      if (reg_wr && reg_addr == `IPPS_A_SAVE)
      begin
        shadow_ctrl_r <= ctrl_r;
        shadow_cnt_r  <= cnt_r;
      end
    end
  end
  // table writes; memories carry no reset
  always @(posedge clk)
  begin
    if (reg_wr && tbl_sel)
    begin
      case (w_fld)
        `IPPS_F_LEN:     len_m[w_ent]  <= reg_wdata[TW-1:0];
        `IPPS_F_EXP_ON:  eon_m[w_ent]  <= reg_wdata[TW-1:0];
        `IPPS_F_EXP_OFF: eoff_m[w_ent] <= reg_wdata[TW-1:0];
        `IPPS_F_STB_ON:  son_m[w_ent]  <= reg_wdata[TW-1:0];
        `IPPS_F_STB_OFF: soff_m[w_ent] <= reg_wdata[TW-1:0];
        `IPPS_F_PWM_PER: per_m[w_ent]  <= reg_wdata[TW-1:0];
        `IPPS_F_PWM_DUTY:
          duty_m[{w_ent, reg_wdata[31:30]}] <= {2'h0, reg_wdata[TW-3:0]};
        default: ;
      endcase
    end
    else if (restore_r)
    begin
      for (k = 0; k < NI; k = k + 1)
      begin
        len_m[k]  <= shadow_m[k*6+0];
        eon_m[k]  <= shadow_m[k*6+1];
        eoff_m[k] <= shadow_m[k*6+2];
        son_m[k]  <= shadow_m[k*6+3];
        soff_m[k] <= shadow_m[k*6+4];
        per_m[k]  <= shadow_m[k*6+5];
      end
      for (k = 0; k < NI*NC; k = k + 1)
        duty_m[k] <= shadow_d[k];   // all channels of every entry
    end
    // save snapshot here so a single process owns the loop index
    if (reg_wr && reg_addr == `IPPS_A_SAVE)
    begin
      for (k = 0; k < NI; k = k + 1)
      begin
        shadow_m[k*6+0] <= len_m[k];
        shadow_m[k*6+1] <= eon_m[k];
        shadow_m[k*6+2] <= eoff_m[k];
        shadow_m[k*6+3] <= son_m[k];
        shadow_m[k*6+4] <= soff_m[k];
        shadow_m[k*6+5] <= per_m[k];
      end
      for (k = 0; k < NI*NC; k = k + 1)
        shadow_d[k] <= duty_m[k];
    end
  end
  // -----------------------------------------------------------------
  // sequencer state machine
  // -----------------------------------------------------------------
  wire [TW-1:0] t_nxt  = t_r + {{(TW-1){1'b0}}, 1'b1};
  wire          last   = ({1'b0, idx_r} + 5'h01) >= cnt_r;
  wire          iv_end = tick && (t_nxt >= len_m[idx_r]);
  wire          run_en = ctrl_r[`IPPS_B_RUN];
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      idx_r   <= 4'h0;
      t_r     <= {TW{1'b0}};
      busy    <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          t_r <= {TW{1'b0}};
          idx_r <= 4'h0;
          if (trig && run_en && cnt_r != 5'h00)
          begin
            state_r <= S_RUN;
            busy    <= 1'b1;
          end
        end
        S_RUN:
        begin
          if (!run_en)
          begin
            state_r <= S_IDLE;
            busy    <= 1'b0;
          end
          else if (iv_end)
          begin
            t_r <= {TW{1'b0}};
            if (last)
            begin
              state_r <= S_IDLE;
              busy    <= 1'b0;
            end
            else
              idx_r <= idx_r + 4'h1;
          end
          else if (tick)
            t_r <= t_nxt;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end
  // -----------------------------------------------------------------
  // window pulses
  // -----------------------------------------------------------------
  wire running = (state_r == S_RUN) && run_en;
  wire exp_w = running && (t_r >= eon_m[idx_r]) && (t_r < eoff_m[idx_r]);
  wire stb_w = running && (t_r >= son_m[idx_r]) && (t_r < soff_m[idx_r]);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exp_pulse  <= 1'b0;
      stb_pulse  <= 1'b0;
      sensor_exp <= 1'b0;
    end
    else
    begin
      exp_pulse  <= exp_w;
      stb_pulse  <= stb_w ^ ctrl_r[`IPPS_B_STB_POL];
      // integration opens at the exposure edge, closes at strobe timing
      if (exp_w && !exp_pulse)
        sensor_exp <= 1'b1;
      else if (!running || (sensor_exp && !stb_w && t_r >= soff_m[idx_r]))
        sensor_exp <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // pwm period counter and channels
  // -----------------------------------------------------------------
  wire pwm_on = running && ctrl_r[`IPPS_B_PWM];
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      pc_r <= {TW{1'b0}};
    else if (!pwm_on || (iv_end))
      pc_r <= {TW{1'b0}};   // restart period at interval start
    else if (tick)
      pc_r <= (pc_r + {{(TW-1){1'b0}}, 1'b1} >= per_m[idx_r]) ? {TW{1'b0}} : pc_r + {{(TW-1){1'b0}}, 1'b1};
  end
  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1)
    begin : g_ch
      ipps_pwm_chan #(.TW(TW)) u_ch
      (
        .clk     (clk),
        .rst     (rst),
        .en      (pwm_on),
        .tick    (tick),
        .pwm_cnt (pc_r),
        .duty    (duty_m[idx_r*NC+g]),
        .pwm_o   (pwm_out[g])
      );
    end
  endgenerate
  // -----------------------------------------------------------------
  // register read
  // -----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      if (tbl_sel && w_fld == `IPPS_F_LEN)
        reg_rdata <= len_m[w_ent];
      else if (tbl_sel && w_fld == `IPPS_F_PWM_PER)
        reg_rdata <= per_m[w_ent];
      else if (reg_addr == `IPPS_A_CTRL)
        reg_rdata <= {27'h0, ctrl_r};
      else if (reg_addr == `IPPS_A_STATUS)
        reg_rdata <= {24'h0, idx_r, pwm_on, sensor_exp, exp_pulse, busy};
      else if (reg_addr == `IPPS_A_COUNT)
        reg_rdata <= {27'h0, cnt_r};
      else
        reg_rdata <= 32'h0;
    end
    else
      reg_rdata <= 32'h0;
  end
endmodule

/* ipps_line_drv.sv */
// hardware trigger line model for the sequencer bench
`timescale 1ns/1ps
module ipps_line_drv
(
  input  wire clk,           // system clock
  input  wire fire,          // bench asks for one trigger pulse
  output reg  line_o = 1'b0  // hardware trigger line, idle low
);
  // ------------------------------
  // pulse shaping
  // ------------------------------
  integer hold_r = 0;        // cycles left in the pulse
  // pulse held six clocks so a 3-flop synchroniser cannot miss it
  always @(posedge clk)
  begin
    if (fire)
      hold_r <= 6;
    else if (hold_r > 0)
      hold_r <= hold_r - 1;
    line_o <= fire || (hold_r > 1);
  end
endmodule

/* ipps_seq_sva.sv */
// port assertions for the interval sequencer
`timescale 1ns/1ps
module ipps_seq_sva
#(
  parameter NC = 4
)
(
  input wire          clk,
  input wire          rst,
  input wire [7:0]    reg_addr,
  input wire [31:0]   reg_wdata,
  input wire          reg_wr,
  input wire          trig_line,
  input wire          exp_pulse,
  input wire          stb_pulse,
  input wire          sensor_exp,
  input wire [NC-1:0] pwm_out,
  input wire          busy
);
  // ------------------------------
  // control shadow
  // ------------------------------
  reg  [4:0] ctl_r;          // copy of the control word from bus writes
  wire       sw_hit;         // software trigger write while idle
  assign sw_hit = reg_wr && reg_addr == 8'h03 && !busy;
  // rebuilt from writes so the checker needs no internal probe
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      ctl_r <= 5'h00;
    else if (reg_wr && reg_addr == 8'h00)
      ctl_r <= reg_wdata[4:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------
  // assertions
  // ------------------------------
  chk_sw_start: assert property (sw_hit && ctl_r[3] && ctl_r[0] |-> ##2 busy)
    else $error("software trigger did not start the run");
  chk_sw_refused: assert property (sw_hit && !ctl_r[3] && !ctl_r[2] |-> ##2 !busy)
    else $error("software trigger taken while disabled");
  chk_hw_start: assert property ($rose(trig_line) && ctl_r[2] && ctl_r[0] && !busy |-> ##[2:8] busy)
    else $error("line trigger did not start the run");
  chk_run_gate: assert property (!ctl_r[0] && !$past(ctl_r[0]) |-> !busy)
    else $error("sequencer runs while run is off");
  chk_pwm_gate: assert property (!ctl_r[1] && !$past(ctl_r[1]) && !$past(ctl_r[1], 2) |-> pwm_out == '0)
    else $error("pwm toggles while disabled");
  chk_idle_quiet: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> !exp_pulse && !sensor_exp)
    else $error("exposure active while idle");
  chk_strobe_pol: assert property (!busy && !$past(busy) && !$past(busy, 2) && ctl_r[4] == $past(ctl_r[4])
    |-> stb_pulse == ctl_r[4])
    else $error("idle strobe level ignores polarity");
  chk_sensor_exp: assert property ($rose(sensor_exp) |-> exp_pulse)
    else $error("sensor exposure began without exposure pulse");
endmodule
bind ipps_seq ipps_seq_sva #(.NC(NC)) i_ipps_seq_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .trig_line(trig_line), .exp_pulse(exp_pulse),
  .stb_pulse(stb_pulse), .sensor_exp(sensor_exp), .pwm_out(pwm_out), .busy(busy));

/* tb.sv */
// self-checking bench for the interval sequencer
`timescale 1ns/1ps
module tb;
  // ------------------------------
  // signals and counters
  // ------------------------------
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         fire = 1'b0;   // line model request
  reg         b1 = 1'b0;     // busy one cycle ago
  reg  [31:0] v;             // last read data
  wire [31:0] reg_rdata;
  wire        trig_line, exp_pulse, stb_pulse, sensor_exp, busy;
  wire [3:0]  pwm_out;
  integer     fails = 0, num_checks = 0, cyc = 0, k, j, nb = 0, ne = 0, ns = 0, nx = 0;
  integer     np [0:3];      // pwm high cycles per channel
  always #10 clk = ~clk;
  ipps_seq #(.TW(32), .NI(16), .NC(4)) i_ipps_seq (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_line(trig_line),
    .exp_pulse(exp_pulse), .stb_pulse(stb_pulse), .sensor_exp(sensor_exp), .pwm_out(pwm_out), .busy(busy));
  ipps_line_drv i_ipps_line_drv (.clk(clk), .fire(fire), .line_o(trig_line));
  // activity counters; pwm counted while running plus one cycle of output lag
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    b1 <= busy;
    nb <= nb + busy;
    ne <= ne + exp_pulse;
    ns <= ns + stb_pulse;
    nx <= nx + sensor_exp;
    for (k = 0; k < 4; k = k + 1)
      np[k] <= np[k] + (pwm_out[k] & (busy | b1));
    if (cyc == 20000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task report_and_stop;
  begin
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task check(input string what, input [31:0] seen, input [31:0] expv);
  begin
    num_checks = num_checks + 1;
    if (seen !== expv)
    begin
      fails = fails + 1;
      $display("Error %s expected %0h seen %0h", what, expv, seen);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  end
  endtask
  task tk(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  // bounded wait for the run flag
  task wait_busy(input lvl);
    integer i;
  begin
    for (i = 0; i < 200 && busy !== lvl; i = i + 1)
      tk(1);
    check("busy", busy, lvl);
  end
  endtask
  // one table entry: tick counts only, exposure inside the interval, short pwm period
  task prog(input [3:0] e, input [29:0] len, e0, e1, s0, s1, per, d0, d1, d2, d3);
  begin
    wr({1'b1, e, 3'h0}, len);
    wr({1'b1, e, 3'h1}, e0);
    wr({1'b1, e, 3'h2}, e1);
    wr({1'b1, e, 3'h3}, s0);
    wr({1'b1, e, 3'h4}, s1);
    wr({1'b1, e, 3'h5}, per);
    wr({1'b1, e, 3'h6}, {2'h0, d0});
    wr({1'b1, e, 3'h6}, {2'h1, d1});
    wr({1'b1, e, 3'h6}, {2'h2, d2});
    wr({1'b1, e, 3'h6}, {2'h3, d3});
  end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  // two differing intervals from a software start
  task t_run;
    integer b0, e0, s0, x0, w;
    integer q [0:3];
  begin
    prog(4'h0, 40, 2, 12, 5, 9, 8, 8, 0, 4, 2);
    prog(4'h1, 24, 0, 20, 3, 24, 6, 0, 3, 6, 1);
    wr(8'h02, 32'h2);
    wr(8'h00, 32'h0b);
    tk(1);
    b0 = nb;
    e0 = ne;
    s0 = ns;
    x0 = nx;
    for (w = 0; w < 4; w = w + 1)
      q[w] = np[w];
    wr(8'h03, 32'h1);
    wait_busy(1'b1);
    for (w = 0; w < 60 && exp_pulse !== 1'b1; w = w + 1)
      tk(1);
    for (w = 0; w < 60 && exp_pulse === 1'b1; w = w + 1)
      tk(1);
    check("first exposure", w, 10);
    wait_busy(1'b0);
    tk(4);
    check("run length", nb - b0, 64);
    check("exposure ticks", ne - e0, 30);
    check("strobe ticks", ns - s0, 25);
    check("sensor ticks", nx - x0, 31);
    check("pwm0", np[0] - q[0], 40);
    check("pwm1", np[1] - q[1], 12);
    check("pwm2", np[2] - q[2], 44);
    check("pwm3", np[3] - q[3], 14);
  end
  endtask
  // line start of a single interval with inverted strobe
  task t_hw;
    integer b0;
  begin
    wr(8'h02, 32'h1);
    wr(8'h00, 32'h17);
    tk(2);
    check("strobe idle", stb_pulse, 1);
    b0 = nb;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    tk(2);
    check("single run", nb - b0, 40);
    check("strobe back", stb_pulse, 1);
  end
  endtask
  // refused starts and disabled pwm
  task t_gate;
    integer q;
  begin
    wr(8'h00, 32'h08);
    wr(8'h03, 32'h1);
    tk(6);
    check("no run", busy, 0);
    wr(8'h00, 32'h01);
    wr(8'h03, 32'h1);
    tk(6);
    check("no sw start", busy, 0);
    wr(8'h00, 32'h09);
    q = np[0];
    wr(8'h03, 32'h1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    tk(2);
    check("pwm off", np[0] - q, 0);
    wr(8'h03, 32'h1);
    wait_busy(1'b1);
    tk(4);
    wr(8'h00, 32'h08);
    tk(2);
    check("abort", busy, 0);
    check("abort exposure", exp_pulse, 0);
  end
  endtask
  // read back, clamping, unmapped place, snapshot and reload
  task t_regs;
  begin
    wr(8'hf8, 32'h55);
    rd(8'hf8);
    check("last entry", v, 32'h55);
    wr(8'h02, 32'h14);
    rd(8'h02);
    check("count clamp", v, 32'h10);
    rd(8'h40);
    check("unmapped", v, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h80, 32'h7);
    wr(8'h05, 32'h1);
    rd(8'h80);
    check("restored", v, 32'h28);
  end
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    for (j = 0; j < 4; j = j + 1)
      np[j] = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_run;
    t_hw;
    t_gate;
    t_regs;
    report_and_stop;
  end
endmodule
